// >>> icu_cfg_pkg.sv
`default_nettype none
package icu_cfg_pkg;

	// register byte offsets on the APB
	localparam logic [7:0] OFF_DECIM     = 8'h00;
	localparam logic [7:0] OFF_DESC      = 8'h04;
	localparam logic [7:0] OFF_CODEC     = 8'h08;
	localparam logic [7:0] OFF_Y2R_A     = 8'h0C;
	localparam logic [7:0] OFF_Y2R_B     = 8'h10;
	localparam logic [7:0] OFF_R2Y_A     = 8'h14;
	localparam logic [7:0] OFF_R2Y_B     = 8'h18;
	localparam logic [7:0] OFF_R2Y_C     = 8'h1C;

	// register indices from the address decoder
	localparam logic [3:0] IDX_DECIM     = 4'h0;
	localparam logic [3:0] IDX_DESC      = 4'h1;
	localparam logic [3:0] IDX_CODEC     = 4'h2;
	localparam logic [3:0] IDX_Y2R_A     = 4'h3;
	localparam logic [3:0] IDX_Y2R_B     = 4'h4;
	localparam logic [3:0] IDX_R2Y_A     = 4'h5;
	localparam logic [3:0] IDX_R2Y_B     = 4'h6;
	localparam logic [3:0] IDX_R2Y_C     = 4'h7;
	localparam logic [3:0] IDX_NONE      = 4'hF;

	// reset values
	localparam logic [7:0]  RST_DECIM    = 8'h10;
	localparam logic [31:0] RST_DESC     = 32'h00000000;
	localparam logic [31:0] RST_CODEC    = 32'h00000000;
	localparam logic [31:0] RST_Y2R_A    = 32'h6832CC95;
	localparam logic [31:0] RST_Y2R_B    = 32'h00007102;
	localparam logic [31:0] RST_R2Y_A    = 32'h01324145;
	localparam logic [31:0] RST_R2Y_B    = 32'h01245E38;
	localparam logic [31:0] RST_R2Y_C    = 32'h01384A4B;

	// writable bits; the rest read as zero
	localparam logic [31:0] MASK_DESC    = 32'hFFFFFFFC;
	localparam logic [31:0] MASK_Y2R_B   = 32'h000071FF;
	localparam logic [31:0] MASK_R2Y     = 32'h01FFFFFF;

	// field positions
	localparam int C4_MSB    = 8;
	localparam int YOFF_BIT  = 12;
	localparam int CROFF_BIT = 13;
	localparam int CBOFF_BIT = 14;
	localparam int COFF_BIT  = 24;

	// decimation and conversion constants
	localparam logic [7:0] DECIM_NONE_MAX = 8'h10;
	localparam logic [9:0] OFF_128        = 10'h080;
	localparam logic [9:0] OFF_16         = 10'h010;
	localparam int         FRAC_BITS      = 9;

endpackage
`default_nettype wire

// >>> icu_cfg_regs.sv
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module icu_cfg_regs
	import icu_cfg_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              curDescValid,
	input  wire logic [31:0]       curDescPtr,
	output logic [7:0]             decimationFactor,
	output logic                   decimationActive,
	output logic [31:0]            previewQueuePointer,
	output logic [31:0]            codecDmaBase,
	input  wire logic              y2rValid,
	input  wire logic [7:0]        yIn,
	input  wire logic [7:0]        cbIn,
	input  wire logic [7:0]        crIn,
	output logic                   rgbValid,
	output logic [7:0]             rOut,
	output logic [7:0]             gOut,
	output logic [7:0]             bOut,
	input  wire logic              r2yValid,
	input  wire logic [7:0]        rIn,
	input  wire logic [7:0]        gIn,
	input  wire logic [7:0]        bIn,
	output logic                   yuvValid,
	output logic [7:0]             yOut,
	output logic [7:0]             cbOut,
	output logic [7:0]             crOut
);

	typedef struct packed {
		logic [7:0]  decim;
		logic [31:0] descPtr;
		logic [31:0] codecBase;
		logic [31:0] y2rA;
		logic [31:0] y2rB;
		logic [31:0] r2yA;
		logic [31:0] r2yB;
		logic [31:0] r2yC;
		logic [31:0] rdData;
		logic        slvErr;
		logic [7:0]  rgbR;
		logic [7:0]  rgbG;
		logic [7:0]  rgbB;
		logic        rgbVld;
		logic [7:0]  yuvY;
		logic [7:0]  yuvCb;
		logic [7:0]  yuvCr;
		logic        yuvVld;
	} icu_state_s;

	icu_state_s st_reg;
	icu_state_s st_next;

	// if-else address decode, shared by the read and write paths
	function automatic logic [3:0] icuRegIndex(input logic [ADDR_W-1:0] a);
		logic [7:0] a8;
		a8 = 8'(a);
		if (ADDR_W > 8 && (a >> 8) != '0)
			return IDX_NONE;
		else if (a8 == OFF_DECIM)
			return IDX_DECIM;
		else if (a8 == OFF_DESC)
			return IDX_DESC;
		else if (a8 == OFF_CODEC)
			return IDX_CODEC;
		else if (a8 == OFF_Y2R_A)
			return IDX_Y2R_A;
		else if (a8 == OFF_Y2R_B)
			return IDX_Y2R_B;
		else if (a8 == OFF_R2Y_A)
			return IDX_R2Y_A;
		else if (a8 == OFF_R2Y_B)
			return IDX_R2Y_B;
		else if (a8 == OFF_R2Y_C)
			return IDX_R2Y_C;
		else
			return IDX_NONE;
	endfunction

	// coefficient times signed sample, scaled up to 1/512 units
	function automatic logic signed [23:0] icuTerm(
		input logic [8:0]        coef,
		input logic signed [9:0] x,
		input logic [1:0]        up
	);
		logic signed [23:0] p;
		p = $signed({15'h0000, coef}) * $signed({{14{x[9]}}, x});
		return p <<< up;
	endfunction

	// round half up from 1/512 units, then clip to 0..255
	function automatic logic [7:0] icuClip(input logic signed [23:0] acc);
		logic signed [23:0] r;
		r = (acc + 24'sh000100) >>> FRAC_BITS;
		if (r < 0)
			return 8'h00;
		else if (r > 24'sh0000FF)
			return 8'hFF;
		else
			return r[7:0];
	endfunction

	// unsigned pixel less an optional offset, as signed 10 bits
	function automatic logic signed [9:0] icuSub(
		input logic [7:0] v,
		input logic       en,
		input logic [9:0] off
	);
		return $signed({2'b00, v} - (en ? off : 10'h000));
	endfunction

	// an optional output offset in 1/512 units
	function automatic logic signed [23:0] icuOff(
		input logic       en,
		input logic [9:0] off
	);
		return en ? $signed({5'h00, off, 9'h000}) : 24'sh000000;
	endfunction

	logic [3:0]         regIdx;
	logic               wrStrobe;
	logic signed [9:0]  yS;
	logic signed [9:0]  crS;
	logic signed [9:0]  cbS;
	logic signed [9:0]  rS;
	logic signed [9:0]  gS;
	logic signed [9:0]  bS;
	logic signed [23:0] yTerm;

	assign regIdx   = icuRegIndex(paddr);
	// zero wait states: access phase always completes at once
	assign pready   = psel & penable;
	assign wrStrobe = psel & penable & pwrite;

	// conversion inputs with selected offsets removed
	always_comb begin
		yS  = icuSub(yIn, st_reg.y2rB[YOFF_BIT], OFF_128);
		crS = icuSub(crIn, st_reg.y2rB[CROFF_BIT], OFF_16);
		cbS = icuSub(cbIn, st_reg.y2rB[CBOFF_BIT], OFF_16);
		rS  = icuSub(rIn, 1'b0, OFF_16);
		gS  = icuSub(gIn, 1'b0, OFF_16);
		bS  = icuSub(bIn, 1'b0, OFF_16);
		yTerm = icuTerm({1'b0, st_reg.y2rA[7:0]}, yS, 2'd2);
	end

	// next-state: bus writes, pointer tracking, read data, converters
	always_comb begin
		st_next = st_reg;
		// datapath moving to a new buffer updates the pointer
		if (curDescValid)
			st_next.descPtr = curDescPtr & MASK_DESC;
		// a bus write wins over a same-cycle datapath update
		if (wrStrobe) begin
			case (regIdx)
				IDX_DECIM: st_next.decim = pwdata[7:0];
				IDX_DESC:  st_next.descPtr = pwdata & MASK_DESC;
				IDX_CODEC: st_next.codecBase = pwdata;
				IDX_Y2R_A: st_next.y2rA = pwdata;
				IDX_Y2R_B: st_next.y2rB = pwdata & MASK_Y2R_B;
				IDX_R2Y_A: st_next.r2yA = pwdata & MASK_R2Y;
				IDX_R2Y_B: st_next.r2yB = pwdata & MASK_R2Y;
				IDX_R2Y_C: st_next.r2yC = pwdata & MASK_R2Y;
				default: ;
			endcase
		end
		// read data and error captured in the setup cycle
		if (psel && !penable) begin
			st_next.slvErr = (regIdx == IDX_NONE);
			case (regIdx)
				IDX_DECIM: st_next.rdData = {24'h000000, st_reg.decim};
				IDX_DESC:  st_next.rdData = st_reg.descPtr;
				IDX_CODEC: st_next.rdData = st_reg.codecBase;
				IDX_Y2R_A: st_next.rdData = st_reg.y2rA;
				IDX_Y2R_B: st_next.rdData = st_reg.y2rB;
				IDX_R2Y_A: st_next.rdData = st_reg.r2yA;
				IDX_R2Y_B: st_next.rdData = st_reg.r2yB;
				IDX_R2Y_C: st_next.rdData = st_reg.r2yC;
				default:   st_next.rdData = 32'h00000000;
			endcase
		end
		// YCbCr to RGB, coefficients in 1/128 steps
		st_next.rgbVld = y2rValid;
		if (y2rValid) begin
			st_next.rgbR = icuClip(yTerm
				+ icuTerm({1'b0, st_reg.y2rA[15:8]}, crS, 2'd2));
			st_next.rgbG = icuClip(yTerm
				- icuTerm({1'b0, st_reg.y2rA[23:16]}, crS, 2'd2)
				- icuTerm({1'b0, st_reg.y2rA[31:24]}, cbS, 2'd2));
			st_next.rgbB = icuClip(yTerm
				+ icuTerm(st_reg.y2rB[C4_MSB:0], cbS, 2'd2));
		end
		// RGB to YCbCr; shift brings each step to 1/512
		st_next.yuvVld = r2yValid;
		if (r2yValid) begin
			st_next.yuvY = icuClip(
				icuTerm({1'b0, st_reg.r2yA[7:0]}, rS, 2'd1)
				+ icuTerm({1'b0, st_reg.r2yA[15:8]}, gS, 2'd2)
				+ icuTerm({1'b0, st_reg.r2yA[23:16]}, bS, 2'd0)
				+ icuOff(st_reg.r2yA[COFF_BIT], OFF_16));
			st_next.yuvCr = icuClip(
				icuTerm({1'b0, st_reg.r2yB[7:0]}, rS, 2'd2)
				- icuTerm({1'b0, st_reg.r2yB[15:8]}, gS, 2'd1)
				- icuTerm({1'b0, st_reg.r2yB[23:16]}, bS, 2'd0)
				+ icuOff(st_reg.r2yB[COFF_BIT], OFF_128));
			// third set: bits 7:0 weigh red, 15:8 green, 23:16 blue
			st_next.yuvCb = icuClip(
				icuTerm({1'b0, st_reg.r2yC[23:16]}, bS, 2'd2)
				- icuTerm({1'b0, st_reg.r2yC[7:0]}, rS, 2'd0)
				- icuTerm({1'b0, st_reg.r2yC[15:8]}, gS, 2'd1)
				+ icuOff(st_reg.r2yC[COFF_BIT], OFF_128));
		end
	end

	// the single state register
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg           <= '0;
			st_reg.decim     <= RST_DECIM;
			st_reg.descPtr   <= RST_DESC;
			st_reg.codecBase <= RST_CODEC;
			st_reg.y2rA      <= RST_Y2R_A;
			st_reg.y2rB      <= RST_Y2R_B;
			st_reg.r2yA      <= RST_R2Y_A;
			st_reg.r2yB      <= RST_R2Y_B;
			st_reg.r2yC      <= RST_R2Y_C;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs from the state register; pslverr is gated by pready
	assign prdata              = st_reg.rdData;
	assign pslverr             = pready & st_reg.slvErr;
	assign decimationFactor    = st_reg.decim;
	// factors up to 16 leave the preview path undecimated
	assign decimationActive    = st_reg.decim > DECIM_NONE_MAX;
	assign previewQueuePointer = st_reg.descPtr;
	assign codecDmaBase        = st_reg.codecBase;
	assign rgbValid            = st_reg.rgbVld;
	assign rOut                = st_reg.rgbR;
	assign gOut                = st_reg.rgbG;
	assign bOut                = st_reg.rgbB;
	assign yuvValid            = st_reg.yuvVld;
	assign yOut                = st_reg.yuvY;
	assign cbOut               = st_reg.yuvCb;
	assign crOut               = st_reg.yuvCr;

	// checks on the register bank and converters
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence wrTo(logic [3:0] idx);
		psel && penable && pwrite && regIdx == idx;
	endsequence

	sequence rdSetup(logic [3:0] idx);
		psel && !penable && !pwrite && regIdx == idx;
	endsequence

	decim_write_a: assert property (wrTo(IDX_DECIM) |=>
		decimationFactor == $past(pwdata[7:0]))
		else $error("decimation factor not loaded from write");

	decim_read_a: assert property (
		rdSetup(IDX_DECIM) ##1 pready |->
		prdata == {24'h000000, $past(decimationFactor)} && !pslverr)
		else $error("decimation factor read returns wrong data");

	// active exactly when the factor is above 16
	no_decim_a: assert property (
		(decimationFactor <= 8'h10) != decimationActive)
		else $error("decimation active at a factor of 16 or less");

	desc_load_a: assert property (wrTo(IDX_DESC) |=>
		previewQueuePointer == {$past(pwdata[31:2]), 2'b00})
		else $error("descriptor base not loaded from write");

	desc_track_a: assert property (
		curDescValid && !(wrStrobe && regIdx == IDX_DESC) |=>
		previewQueuePointer == {$past(curDescPtr[31:2]), 2'b00})
		else $error("descriptor pointer does not follow datapath");

	desc_align_a: assert property (
		previewQueuePointer[1:0] == 2'b00)
		else $error("descriptor pointer not word aligned");

	codec_base_a: assert property (wrTo(IDX_CODEC) |=>
		codecDmaBase == $past(pwdata) ##1 (codecDmaBase == $past(codecDmaBase)
		|| $past(wrStrobe)))
		else $error("codec base not loaded from write");

	y2r_read_a: assert property (rdSetup(IDX_Y2R_A) ##1 pready |->
		prdata == st_reg.y2rA && !pslverr)
		else $error("coefficient read returns wrong data");

	y2r_mask_a: assert property (
		(st_reg.y2rB & ~MASK_Y2R_B) == 32'h00000000)
		else $error("reserved coefficient bits set");

	r2y_mask_a: assert property (
		((st_reg.r2yA | st_reg.r2yB | st_reg.r2yC) & ~MASK_R2Y) == 32'h0)
		else $error("reserved conversion bits set");

	conv_latency_a: assert property (
		y2rValid && r2yValid |=> rgbValid && yuvValid)
		else $error("converter output not one cycle after input");

	bad_addr_a: assert property (psel && !penable && regIdx == IDX_NONE
		##1 pready |-> pslverr && prdata == 32'h00000000)
		else $error("unmapped address not refused");

endmodule
`default_nettype wire

// >>> icu_cfg_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module icu_cfg_regs_test;
	import icu_cfg_pkg::*;
	logic        clk = 1'b0, rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, curDescPtr = 32'h0, prdata;
	logic        curDescValid = 1'b0, y2rValid = 1'b0, r2yValid = 1'b0;
	logic [7:0]  yIn = 8'h00, cbIn = 8'h00, crIn = 8'h00;
	logic [7:0]  rIn = 8'h00, gIn = 8'h00, bIn = 8'h00;
	logic        pready, pslverr, decimationActive, rgbValid, yuvValid;
	logic [7:0]  decimationFactor, rOut, gOut, bOut, yOut, cbOut, crOut;
	logic [31:0] previewQueuePointer, codecDmaBase, v;
	logic [7:0]  offs [8] = '{OFF_DECIM, OFF_DESC, OFF_CODEC, OFF_Y2R_A,
		OFF_Y2R_B, OFF_R2Y_A, OFF_R2Y_B, OFF_R2Y_C};
	logic [31:0] rstv [8] = '{32'h00000010, 32'h0, 32'h0, 32'h6832CC95,
		32'h00007102, 32'h01324145, 32'h01245E38, 32'h01384A4B};
	// writable bits per register, the rest reads zero
	logic [31:0] msk [8] = '{32'h000000FF, 32'hFFFFFFFC, 32'hFFFFFFFF,
		32'hFFFFFFFF, 32'h000071FF, 32'h01FFFFFF, 32'h01FFFFFF, 32'h01FFFFFF};
	logic [7:0]  decTab [5] = '{8'h00, 8'h10, 8'h11, 8'hFF, 8'h80};
	logic [31:0] sh [8];
	logic [32:0] apbQ [$], rgbQ [$], yuvQ [$];
	logic [31:0] seed = 32'h4E8E;
	int          nMismatch = 0, samplesChecked = 0;

	icu_cfg_regs #(.ADDR_W(8)) i_dut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.curDescValid(curDescValid), .curDescPtr(curDescPtr),
		.decimationFactor(decimationFactor),
		.decimationActive(decimationActive),
		.previewQueuePointer(previewQueuePointer),
		.codecDmaBase(codecDmaBase), .y2rValid(y2rValid), .yIn(yIn),
		.cbIn(cbIn), .crIn(crIn), .rgbValid(rgbValid), .rOut(rOut),
		.gOut(gOut), .bOut(bOut), .r2yValid(r2yValid), .rIn(rIn), .gIn(gIn),
		.bIn(bIn), .yuvValid(yuvValid), .yOut(yOut), .cbOut(cbOut),
		.crOut(crOut));

	always #4 clk = ~clk;

	function automatic logic [31:0] nextRand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] clip(input int x);
		return x < 0 ? 8'h00 : (x > 255 ? 8'hFF : x[7:0]);
	endfunction

	// round half up after dropping n fraction bits
	function automatic int rnd(input int s, input int n);
		return (s + (1 <<< (n - 1))) >>> n;
	endfunction

	// colour models built from the register shadow
	function automatic logic [32:0] y2rExp(input logic [31:0] p);
		int c [5];
		int y, cb, cr;
		for (int i = 0; i < 4; i++) c[i] = int'(sh[3][8*i+:8]);
		c[4] = int'(sh[4][8:0]);
		y = int'(p[7:0]) - (sh[4][12] ? 128 : 0);
		cb = int'(p[15:8]) - (sh[4][14] ? 16 : 0);
		cr = int'(p[23:16]) - (sh[4][13] ? 16 : 0);
		return {9'h0, clip(rnd(c[0]*y + c[1]*cr, 7)),
			clip(rnd(c[0]*y - c[2]*cr - c[3]*cb, 7)),
			clip(rnd(c[0]*y + c[4]*cb, 7))};
	endfunction

	function automatic logic [32:0] r2yExp(input logic [31:0] p);
		int c [9];
		int r, g, b;
		for (int i = 0; i < 9; i++) c[i] = int'(sh[5+i/3][8*(i%3)+:8]);
		r = int'(p[7:0]);
		g = int'(p[15:8]);
		b = int'(p[23:16]);
		return {9'h0, clip(rnd(2*c[0]*r + 4*c[1]*g + c[2]*b, 9)
				+ (sh[5][24] ? 16 : 0)),
			clip(rnd(-c[6]*r - 2*c[7]*g + 4*c[8]*b, 9) + (sh[7][24] ? 128 : 0)),
			clip(rnd(4*c[3]*r - 2*c[4]*g - c[5]*b, 9) + (sh[6][24] ? 128 : 0))};
	endfunction

	task automatic chk(input string nm, input logic [32:0] seen,
		input logic [32:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic take(input string nm, input logic [32:0] seen,
		ref logic [32:0] q [$]);
		if (q.size() == 0) chk(nm, seen, 33'h1FFFFFFFF);
		else chk(nm, seen, q.pop_front());
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// one apb transfer; the expected {pslverr, read data} goes to the queue
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		apbQ.push_back(e);
		// only the watchdog ends a wait that never gets an answer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// back-to-back pixels through both converters
	task automatic pix(input int n);
		logic [31:0] a, b;
		repeat (n) begin
			a = nextRand();
			b = nextRand();
			y2rValid <= 1'b1;
			{crIn, cbIn, yIn} <= a[23:0];
			r2yValid <= 1'b1;
			{bIn, gIn, rIn} <= b[23:0];
			rgbQ.push_back(y2rExp(a));
			yuvQ.push_back(r2yExp(b));
			@(posedge clk);
		end
		y2rValid <= 1'b0;
		r2yValid <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// result watcher: pops the oldest note whenever an answer appears
	always @(posedge clk) begin
		if (!rst && psel && penable && pready === 1'b1)
			take("apb", {pslverr, pwrite ? 32'h0 : prdata}, apbQ);
		if (!rst && rgbValid === 1'b1)
			take("rgb", {9'h0, rOut, gOut, bOut}, rgbQ);
		if (!rst && yuvValid === 1'b1)
			take("yuv", {9'h0, yOut, cbOut, crOut}, yuvQ);
	end

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// unmapped places refuse and leave every register alone
		apb(1'b1, 8'h20, nextRand(), {1'b1, 32'h0});
		apb(1'b0, 8'hFC, 32'h0, {1'b1, 32'h0});
		for (int i = 0; i < 8; i++) begin
			sh[i] = rstv[i];
			apb(1'b0, offs[i], 32'h0, {1'b0, rstv[i]});
		end
		pix(6);
		// factor 0..16 means the preview path is not decimated
		for (int i = 0; i < 5; i++) begin
			v = nextRand();
			v[7:0] = decTab[i];
			apb(1'b1, OFF_DECIM, v, 33'h0);
			chk("decim", decimationFactor, decTab[i]);
			chk("active", decimationActive, decTab[i] > 8'h10);
			apb(1'b0, OFF_DECIM, 32'h0, {1'b0, 24'h0, decTab[i]});
		end
		sh[0] = {24'h0, decTab[4]};
		// all ones first, then random words into every register
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 8; i++) begin
				v = (k == 0) ? 32'hFFFFFFFF : nextRand();
				apb(1'b1, offs[i], v, 33'h0);
				sh[i] = v & msk[i];
				apb(1'b0, offs[i], 32'h0, {1'b0, sh[i]});
			end
			chk("queue", previewQueuePointer, sh[1]);
			chk("codec", codecDmaBase, sh[2]);
			chk("decim", decimationFactor, sh[0][7:0]);
			pix(10);
		end
		// datapath moves the current buffer; reads follow it
		v = nextRand();
		curDescValid <= 1'b1;
		curDescPtr <= v;
		@(posedge clk);
		curDescValid <= 1'b0;
		curDescPtr <= nextRand();
		@(negedge clk);
		chk("current", previewQueuePointer, v & 32'hFFFFFFFC);
		@(posedge clk);
		apb(1'b0, OFF_DESC, 32'h0, {1'b0, v & 32'hFFFFFFFC});
		chk("pending", apbQ.size() + rgbQ.size() + yuvQ.size(), 33'h0);
		report_and_stop();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		nMismatch++;
		report_and_stop();
	end
endmodule
`default_nettype wire
